// ### rtl/count_unit.sv
// One counter/timer channel with five modes.
// Assumes tick is a one-cycle pulse and ctrl is already in the pclk domain.
`default_nettype none
module count_unit import qct_pkg::*; #(
  parameter int CNT_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick,     // Prescaled counter clock pulse
  input  wire logic             run,      // Channel enable
  input  wire mode_t            mode,     // Operating mode
  input  wire logic [CNT_W-1:0] reload,   // End or start value
  input  wire logic             ctrl,     // Gate, trigger or kick
  output logic      [CNT_W-1:0] count,
  output logic      [CNT_W-1:0] capture,
  output logic                  out,
  output logic                  tc
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // Running count
    logic [CNT_W-1:0] cap;   // Last captured value
    logic             out;   // Waveform, pulse or expiry level
    logic             tc;    // Terminal count
    logic             ctl_q; // Previous ctrl for edges
    logic             busy;  // Pulse in progress
  } cu_t;
  cu_t s, next_s;
  logic edge_c;
  assign edge_c = ctrl & ~s.ctl_q;

  // Mode behaviour
  always_comb begin
    next_s = s;
    next_s.ctl_q = ctrl;
    next_s.tc = s.tc & ~tick; // Hold for one counter period
    if (!run) begin
      next_s.cnt = (mode == m_wave || mode == m_pulse || mode == m_wdog) ? reload : '0;
      next_s.out = 1'b0;
      next_s.tc = 1'b0;
      next_s.busy = 1'b0;
    end else begin
      case (mode)
        m_wave: begin
          if (tick && ctrl) begin
            if (s.cnt == '0) begin
              next_s.cnt = reload;
              next_s.out = ~s.out;
              next_s.tc = 1'b1;
            end else next_s.cnt = s.cnt - 1'b1;
          end
        end
        m_pulse: begin
          if (edge_c && !s.busy) begin
            next_s.cnt = reload;
            next_s.busy = 1'b1;
            next_s.out = 1'b1;
          end else if (tick && s.busy) begin
            if (s.cnt == '0) begin
              next_s.busy = 1'b0;
              next_s.out = 1'b0;
              next_s.tc = 1'b1;
            end else next_s.cnt = s.cnt - 1'b1;
          end
        end
        m_event: begin
          if (edge_c) begin
            if (s.cnt == reload) begin
              next_s.cnt = '0;
              next_s.tc = 1'b1;
            end else next_s.cnt = s.cnt + 1'b1;
          end
        end
        m_capture: begin
          if (edge_c) next_s.cap = s.cnt;
          if (tick) begin
            next_s.cnt = s.cnt + 1'b1;
            if (s.cnt == '1) next_s.tc = 1'b1;
          end
        end
        m_wdog: begin
          // Kick reloads and clears the output, then counting restarts; expiry holds until kicked
          if (edge_c) begin
            next_s.cnt = reload;
            next_s.out = 1'b0;
          end else if (tick && s.cnt != '0) begin
            next_s.cnt = s.cnt - 1'b1;
            if (s.cnt == CNT_W'(1)) begin
              next_s.out = 1'b1;
              next_s.tc = 1'b1;
            end
          end
        end
        default: next_s = s;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else s <= next_s;
  end
  assign count = s.cnt;
  assign capture = s.cap;
  assign out = s.out;
  assign tc = s.tc;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_trig;
    run && mode == m_pulse && edge_c && !s.busy;
  endsequence
  a_tc_fall_tick: assert property ($fell(s.tc) |-> $past(tick) || $past(!run))
    else $error("terminal count ended off a tick");
  a_wave_reload: assert property (run && mode == m_wave && tick && ctrl && s.cnt == '0
    |=> s.tc && s.cnt == $past(reload)) else $error("waveform did not reload");
  a_pulse_start: assert property (s_trig ##1 run |-> s.out && s.busy)
    else $error("pulse did not start on trigger");
endmodule : count_unit
`default_nettype wire

// ### rtl/irq_ctrl.sv
// Eight-input interrupt controller: sense select, mask, priority.
// Assumes requests and clears are in the pclk domain.
`default_nettype none
module irq_ctrl import qct_pkg::*; (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] req,    // Raw requests
  input  wire logic [7:0] sense,  // 1 edge, 0 level
  input  wire logic [7:0] enable, // Mask, 1 lets through
  input  wire logic [7:0] clr,    // Clear pulses for latched edges
  output logic      [7:0] pend,
  output logic      [3:0] vector, // Valid in bit 3
  output logic            irq
);
  typedef struct packed {
    logic [7:0] req_q; // Previous request levels
    logic [7:0] latch; // Edge latches
    logic [3:0] vec;
    logic       irq;
  } ic_t;
  ic_t s, next_s;
  logic [7:0] act;
  assign pend = (s.latch & sense) | (req & ~sense);
  assign act = pend & enable;

  // Set wins over a same-cycle clear
  always_comb begin
    next_s = s;
    next_s.req_q = req;
    next_s.latch = (s.latch & ~clr) | (req & ~s.req_q);
    next_s.irq = |act;
    next_s.vec = {|act, top_index(act)};
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else s <= next_s;
  end
  assign vector = s.vec;
  assign irq = s.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_irq_masked: assert property (irq |-> $past((pend & enable) != 8'h00))
    else $error("interrupt raised with no enabled request");
  a_prio_top: assert property (vector[3] |-> vector[2:0] == top_index($past(act)))
    else $error("vector is not the highest request");
  a_edge_hold: assert property (1 |=> (s.latch & $past(s.latch & ~clr)) == $past(s.latch & ~clr))
    else $error("latched edge lost without clear");
endmodule : irq_ctrl
`default_nettype wire

// ### rtl/qct_map.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes byte addressing on a 32-bit APB bus, one register per word.
`ifndef QCT_MAP_SVH
`define QCT_MAP_SVH
`define QCT_CLK_HZ       20000000
`define QCT_CNT_MAX_HZ   7500000
`define QCT_MIN_DIV      ((`QCT_CLK_HZ + `QCT_CNT_MAX_HZ - 1) / `QCT_CNT_MAX_HZ)
`define QCT_OFS_PRESCALE 8'h00
`define QCT_OFS_POWER    8'h04
`define QCT_OFS_SENSE    8'h08
`define QCT_OFS_ENABLE   8'h0c
`define QCT_OFS_STATUS   8'h10
`define QCT_OFS_CLEAR    8'h14
`define QCT_OFS_VECTOR   8'h18
`define QCT_OFS_CNT_LO   8'h20
`define QCT_OFS_CNT_HI   8'h5c
`define QCT_RST_DIV      16'h0004
`define QCT_CMD_MODE     2:0
`define QCT_CMD_SRC      4:3
`define QCT_CMD_SWCTL    5
`define QCT_CMD_PINB     6
`define QCT_CMD_RUN      7
`define QCT_PWR_CNT_OFF  0
`define QCT_PWR_LA_OFF   1
`endif

// ### rtl/qct_pkg.sv
// Types shared by the counter/timer block and its parts.
// Assumes the map header is compiled alongside.
`default_nettype none
package qct_pkg;
  // Counter modes, held in the low command bits
  typedef enum logic [2:0] {m_wave, m_pulse, m_event, m_capture, m_wdog} mode_t;
  // Control input sources
  typedef enum logic [1:0] {src_sw, src_pin, src_cell} src_t;
  // Highest set bit wins
  function automatic logic [2:0] top_index(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction : top_index
endpackage : qct_pkg
`default_nettype wire

// ### rtl/quad_counter_timer_with_irq.sv
// Four counter/timers with a shared prescaler and an interrupt controller.
// Assumes an APB master on pclk; logic-array signals share pclk, pins do not.
// Operation
// - Four independent 16-bit counters, one clock
// - Prescaler divides input; counter clock capped
// - Five modes chosen by command register
// - Control source: software, pin or macrocell
// - Waveform and pulse outputs drive port pins
// - Watchdog output goes only to logic array
// - Eight requests: counts, macrocells, product terms
// - Each request level or edge sensitive
// - Highest numbered pending request wins
// - Each request individually maskable
// - Counter and logic-array clocks can stop
`include "qct_map.svh"
`default_nettype none
module quad_counter_timer_with_irq import qct_pkg::*; #(
  parameter int CNT_W = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  ext_ctrl,                // Control pins, unsynchronised
  input  wire logic [3:0]  cell_ctrl,               // Peripheral logic array macrocells
  input  wire logic [1:0]  cell_irq,                // Macrocell interrupt requests
  input  wire logic [1:0]  term_irq,                // Product term requests
  output logic      [3:0]  port_a_out,
  output logic      [3:0]  port_a_oe,
  output logic      [3:0]  port_b_out,
  output logic      [3:0]  port_b_oe,
  output logic      [3:0]  watchdog_to_logic_array,
  output logic             la_clk_en,               // Peripheral logic array clock on
  output logic             irq
);
  // Width must fit the 16-bit data fields
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must be 2..16");
  end

  localparam logic [15:0] MIN_DIV = 16'(`QCT_MIN_DIV);

  typedef struct packed {
    logic [15:0]           div;     // Prescaler divisor
    logic [15:0]           pcnt;    // Prescaler count
    logic                  tick;    // Counter clock pulse
    logic [1:0]            pwr;     // Clock gating bits
    logic [7:0]            sense;   // Request sensitivity
    logic [7:0]            ien;     // Request mask
    logic [7:0]            clr;     // Clear pulses
    logic [3:0][7:0]       cmd;     // Per-counter command
    logic [3:0][CNT_W-1:0] reload;  // Per-counter end or start value
    logic [3:0]            s1;      // Pin sync first stage
    logic [3:0]            s2;      // Pin sync second stage
    logic [3:0]            pa_out;
    logic [3:0]            pa_oe;
    logic [3:0]            pb_out;
    logic [3:0]            pb_oe;
    logic [3:0]            wdog;
    logic                  la_en;
    logic                  ready;
    logic [31:0]           rdata;
    logic                  err;
  } top_t;
  top_t s, next_s;

  // Channel wiring
  logic [3:0][CNT_W-1:0] cnt_val;
  logic [3:0][CNT_W-1:0] cap_val;
  logic [3:0]            ch_out;
  logic [3:0]            ch_tc;
  logic [3:0]            ctrl;
  logic [3:0]            wd_mode;
  logic [3:0]            wp_mode;
  logic [7:0]            pend;
  logic [3:0]            vector;
  logic [7:0]            req;

  // Counter region decode, shared by read and write paths
  function automatic logic in_cnt(input logic [7:0] a);
    return a >= `QCT_OFS_CNT_LO && a <= `QCT_OFS_CNT_HI;
  endfunction : in_cnt

  // Any mapped address
  function automatic logic is_hit(input logic [7:0] a);
    return a[1:0] == 2'b00 && (a <= `QCT_OFS_VECTOR || in_cnt(a));
  endfunction : is_hit

  // Per-channel mode and source selection
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wd_mode[i] = mode_t'(s.cmd[i][`QCT_CMD_MODE]) == m_wdog;
      wp_mode[i] = mode_t'(s.cmd[i][`QCT_CMD_MODE]) == m_wave ||
                   mode_t'(s.cmd[i][`QCT_CMD_MODE]) == m_pulse;
      case (src_t'(s.cmd[i][`QCT_CMD_SRC]))
        src_sw:   ctrl[i] = s.cmd[i][`QCT_CMD_SWCTL];
        src_pin:  ctrl[i] = s.s2[i];
        src_cell: ctrl[i] = cell_ctrl[i];
        default:  ctrl[i] = 1'b0;
      endcase
    end
  end

  // Four identical channels on one tick
  for (genvar g = 0; g < 4; g++) begin : g_ch
    count_unit #(.CNT_W(CNT_W)) u_ch (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (s.tick),
      .run     (s.cmd[g][`QCT_CMD_RUN]),
      .mode    (mode_t'(s.cmd[g][`QCT_CMD_MODE])),
      .reload  (s.reload[g]),
      .ctrl    (ctrl[g]),
      .count   (cnt_val[g]),
      .capture (cap_val[g]),
      .out     (ch_out[g]),
      .tc      (ch_tc[g])
    );
  end

  // Request order fixes priority: product terms on top
  assign req = {term_irq, cell_irq, ch_tc};

  irq_ctrl u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (req),
    .sense   (s.sense),
    .enable  (s.ien),
    .clr     (s.clr),
    .pend    (pend),
    .vector  (vector),
    .irq     (irq)
  );

  // Register read value
  function automatic logic [31:0] rd_val(input logic [7:0] a);
    logic [31:0] r;
    logic [1:0]  ch;
    r = 32'h0;
    ch = 2'((a - `QCT_OFS_CNT_LO) >> 4);
    if (a == `QCT_OFS_PRESCALE) r[15:0] = s.div;
    else if (a == `QCT_OFS_POWER) r[1:0] = s.pwr;
    else if (a == `QCT_OFS_SENSE) r[7:0] = s.sense;
    else if (a == `QCT_OFS_ENABLE) r[7:0] = s.ien;
    else if (a == `QCT_OFS_STATUS) r[7:0] = pend;
    else if (a == `QCT_OFS_VECTOR) r[3:0] = vector;
    else if (in_cnt(a)) begin
      if (a[3:2] == 2'd0) r[7:0] = s.cmd[ch];
      else if (a[3:2] == 2'd1) r[CNT_W-1:0] = s.reload[ch];
      else if (a[3:2] == 2'd2) r[CNT_W-1:0] = cnt_val[ch];
      else r[CNT_W-1:0] = cap_val[ch];
    end
    return r;
  endfunction : rd_val

  // Next state of the whole block
  always_comb begin
    logic [15:0] eff;
    logic [1:0]  ch;
    eff = '0;
    ch = '0;
    next_s = s;
    // Two-stage pin sync; first stage feeds only the second
    next_s.s1 = ext_ctrl;
    next_s.s2 = s.s1;
    // Prescaler with a floor that keeps the counter clock in range
    eff = (s.div < MIN_DIV) ? MIN_DIV : s.div;
    if (s.pwr[`QCT_PWR_CNT_OFF]) begin
      next_s.pcnt = '0;
      next_s.tick = 1'b0;
    end else if (s.pcnt >= eff - 16'd1) begin
      next_s.pcnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.pcnt = s.pcnt + 16'd1;
      next_s.tick = 1'b0;
    end
    next_s.la_en = ~s.pwr[`QCT_PWR_LA_OFF];
    // Output routing
    for (int i = 0; i < 4; i++) begin
      next_s.pa_oe[i] = wp_mode[i] && !s.cmd[i][`QCT_CMD_PINB];
      next_s.pb_oe[i] = wp_mode[i] && s.cmd[i][`QCT_CMD_PINB];
      next_s.pa_out[i] = next_s.pa_oe[i] & ch_out[i];
      next_s.pb_out[i] = next_s.pb_oe[i] & ch_out[i];
      next_s.wdog[i] = wd_mode[i] & ch_out[i];
    end
    // APB: answer one cycle after setup
    next_s.clr = '0;
    next_s.ready = 1'b0;
    next_s.err = 1'b0;
    if (psel && !penable) begin
      next_s.ready = 1'b1;
      next_s.err = !is_hit(paddr);
      next_s.rdata = pwrite ? 32'h0 : rd_val(paddr);
    end
    if (psel && penable && s.ready && pwrite && is_hit(paddr)) begin
      ch = 2'((paddr - `QCT_OFS_CNT_LO) >> 4);
      if (paddr == `QCT_OFS_PRESCALE) next_s.div = pwdata[15:0];
      else if (paddr == `QCT_OFS_POWER) next_s.pwr = pwdata[1:0];
      else if (paddr == `QCT_OFS_SENSE) next_s.sense = pwdata[7:0];
      else if (paddr == `QCT_OFS_ENABLE) next_s.ien = pwdata[7:0];
      else if (paddr == `QCT_OFS_CLEAR) next_s.clr = pwdata[7:0];
      else if (in_cnt(paddr)) begin
        if (paddr[3:2] == 2'd0) next_s.cmd[ch] = pwdata[7:0];
        else if (paddr[3:2] == 2'd1) next_s.reload[ch] = pwdata[CNT_W-1:0];
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.div <= `QCT_RST_DIV;
      s.la_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.err;
  assign port_a_out = s.pa_out;
  assign port_a_oe = s.pa_oe;
  assign port_b_out = s.pb_out;
  assign port_b_oe = s.pb_oe;
  assign watchdog_to_logic_array = s.wdog;
  assign la_clk_en = s.la_en;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_tick_spacing: assert property (s.tick |=> !s.tick [*2])
    else $error("counter clock faster than allowed");
  a_tick_gated: assert property (s.pwr[`QCT_PWR_CNT_OFF] |=> !s.tick)
    else $error("counter clock ran while gated");
  a_la_gated: assert property (s.pwr[`QCT_PWR_LA_OFF] |=> !la_clk_en)
    else $error("logic array clock ran while gated");
  a_wdog_no_pin: assert property (((port_a_oe | port_b_oe) & $past(wd_mode)) == 4'h0)
    else $error("watchdog reached a pin");
  a_route_pin: assert property (wp_mode[3] && !s.cmd[3][`QCT_CMD_PINB]
    |=> port_a_oe[3] && port_a_out[3] == $past(ch_out[3])) else $error("wave not on port pin");
  a_src_pin: assert property (src_t'(s.cmd[3][`QCT_CMD_SRC]) == src_pin
    |-> ctrl[3] == $past(ext_ctrl[3], 2)) else $error("pin source not selected");
endmodule : quad_counter_timer_with_irq
`default_nettype wire

// ### tb/la_model.sv
// Logic array stand-in: macrocells and product terms feeding the block.
// Assumes pclk is shared with the block; the bench drives its inputs.
`default_nettype none
module la_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       la_clk_en, // Array clock gate
  input  wire logic [5:0] mc_in,     // Macrocell terms
  input  wire logic [1:0] port_c_in, // External interrupt pins
  output logic      [3:0] cell_ctrl,
  output logic      [1:0] cell_irq,
  output logic      [1:0] term_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered like real macrocells; frozen while the array clock is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_ctrl <= 4'h0;
      cell_irq  <= 2'h0;
      term_irq  <= 2'h0;
    end else if (la_clk_en) begin
      {cell_irq, cell_ctrl} <= mc_in;
      term_irq <= port_c_in;
    end
  end
endmodule : la_model
`default_nettype wire

// ### tb/test_quad_counter_timer_with_irq.sv
// Self-checking bench for the quad counter/timer with interrupts.
// Assumes the map header, package and design are compiled first.
`include "qct_map.svh"
`default_nettype none
module test_quad_counter_timer_with_irq;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, la_clk_en, irq;
  logic [3:0]  ext_ctrl = 4'h0;      // Control pins
  logic [3:0]  cell_ctrl, pa_out, pa_oe, pb_out, pb_oe, wdog;
  logic [1:0]  cell_irq, term_irq;
  logic [1:0]  port_c_in = 2'h0;     // External interrupt pins
  logic [5:0]  mc_in = 6'h00;        // Macrocell terms
  logic [32:0] exp_q[$];             // Expected {pslverr, prdata} per read
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          seed = 77;
  logic [7:0]  rl;                   // Random wave reload

  quad_counter_timer_with_irq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_ctrl(ext_ctrl), .cell_ctrl(cell_ctrl), .cell_irq(cell_irq),
    .term_irq(term_irq), .port_a_out(pa_out), .port_a_oe(pa_oe), .port_b_out(pb_out),
    .port_b_oe(pb_oe), .watchdog_to_logic_array(wdog), .la_clk_en(la_clk_en), .irq(irq));
  la_model la (.pclk(pclk), .presetn(presetn), .la_clk_en(la_clk_en), .mc_in(mc_in),
    .port_c_in(port_c_in), .cell_ctrl(cell_ctrl), .cell_irq(cell_irq), .term_irq(term_irq));

  // 20 MHz clock
  always #25 pclk = ~pclk;

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Hang guard, far above the planned run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic pin(input logic seen, input logic exp);
    check({32'h0, seen}, {32'h0, exp});
  endtask : pin

  // Read results are compared when they appear
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // One APB transfer; waits on pready, bounded
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    // A transfer that never answers counts as a mismatch
    if (n >= 20) bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped word
    rd(`QCT_OFS_PRESCALE, 33'h4);
    rd(`QCT_OFS_ENABLE, 33'h0);
    rd(`QCT_OFS_VECTOR, 33'h0);
    rd(8'h1c, 33'h1_0000_0000);
    pin(la_clk_en, 1'b1);
    $display("reset test done");
    // Two level requests at once, then masking
    wr(`QCT_OFS_ENABLE, 32'hff);
    port_c_in <= 2'h2;
    mc_in <= 6'h10;
    idle(4);
    rd(`QCT_OFS_STATUS, 33'h90);
    rd(`QCT_OFS_VECTOR, 33'hf);
    pin(irq, 1'b1);
    wr(`QCT_OFS_ENABLE, 32'h7f);
    rd(`QCT_OFS_VECTOR, 33'hc);
    port_c_in <= 2'h0;
    mc_in <= 6'h00;
    idle(4);
    rd(`QCT_OFS_STATUS, 33'h0);
    pin(irq, 1'b0);
    $display("level test done");
    // Short edge request latches until cleared; old latches dropped first
    wr(`QCT_OFS_CLEAR, 32'hff);
    wr(`QCT_OFS_SENSE, 32'h10);
    mc_in <= 6'h10;
    idle(1);
    mc_in <= 6'h00;
    idle(4);
    rd(`QCT_OFS_STATUS, 33'h10);
    pin(irq, 1'b1);
    wr(`QCT_OFS_CLEAR, 32'h10);
    rd(`QCT_OFS_STATUS, 33'h0);
    pin(irq, 1'b0);
    $display("edge test done");
    // Wave mode from a pin, random reload
    rl = {5'h0, 3'($random(seed))} + 8'h1;
    wr(`QCT_OFS_SENSE, 32'hff);
    wr(`QCT_OFS_PRESCALE, 32'h3);
    ext_ctrl <= 4'h8;
    wr(8'h54, {24'h0, rl});
    wr(8'h50, 32'h88);
    idle(60);
    rd(`QCT_OFS_STATUS, 33'h08);
    pin(pa_oe[3], 1'b1);
    pin(pb_oe[3], 1'b0);
    wr(8'h50, 32'h0);
    idle(2);
    pin(pa_out[3], 1'b0);
    $display("wave test done");
    // Stopped counter clock, then watchdog expiry
    wr(`QCT_OFS_CLEAR, 32'hff);
    wr(`QCT_OFS_POWER, 32'h1);
    wr(8'h34, 32'h2);
    wr(8'h30, 32'h84);
    idle(60);
    rd(`QCT_OFS_STATUS, 33'h0);
    pin(wdog[1], 1'b0);
    wr(`QCT_OFS_POWER, 32'h2);
    idle(2);
    pin(la_clk_en, 1'b0);
    wr(`QCT_OFS_POWER, 32'h0);
    idle(60);
    pin(wdog[1], 1'b1);
    pin(pa_oe[1] | pb_oe[1], 1'b0);
    rd(`QCT_OFS_STATUS, 33'h02);
    wr(8'h30, 32'h0);
    $display("watchdog test done");
    // Event count from a macrocell
    wr(`QCT_OFS_CLEAR, 32'hff);
    wr(8'h44, 32'h2);
    wr(8'h40, 32'h92);
    repeat (3) begin
      idle(3);
      mc_in <= 6'h04;
      idle(3);
      mc_in <= 6'h00;
    end
    idle(20);
    rd(`QCT_OFS_STATUS, 33'h04);
    $display("event test done");
    // Software-triggered pulse on port B
    wr(8'h24, 32'h8);
    wr(8'h20, 32'hc1);
    wr(8'h20, 32'he1);
    idle(6);
    pin(pb_oe[0], 1'b1);
    pin(pb_out[0], 1'b1);
    pin(pa_oe[0], 1'b0);
    $display("pulse test done");
    conclude();
  end
endmodule : test_quad_counter_timer_with_irq
`default_nettype wire
